// File: rtl/acr_top.sv
// Behaviour
// [RULE1] clock select 000 /2,100 /4,001 /8,101 /16,010 /32,110 /64,x11 rc
// [RULE2] clock register bit 7 and bits 3..0 read zero, writes ignored
// [RULE3] result register holds 8-bit result, read/write, undefined at reset
// [RULE4] software waits an acquisition period after changing the channel
// [RULE5] at low supply with rc clock, software waits at least 16 us
// [RULE6] acquisition wait is 2 us plus charge plus temperature term
// [RULE7] reference ready bit read-only, one when reference output usable
// [RULE8] wide-supply parts always read reference ready as one
// [RULE9] reference bit 6 enables fixed reference, resets to zero
// [RULE10] reference bit 5 enables temperature indicator, resets to zero
// [RULE11] reference bit 4 selects temperature range, one is high range
// [RULE12] gain field bits 1..0: off, 1x, 2x, 4x reference output
// [RULE13] reference bits 3 and 2 read zero, writes ignored
// [RULE14] fixed reference can be routed to a converter input channel
// [RULE15] reference active for brown-out 11, or 10/01 with fast start
// [RULE16] setting start bit begins conversion, hardware clears it at end
// [RULE17] completion sets done flag and loads result regardless
// [RULE18] channel codes 0..11 external, 1110 temperature, 1111 reference
// [RULE19] early clear of start stores partial result, bits fill with last
// [RULE20] rc-clocked conversion events are synchronised into the bus clock
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
module acr_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rc_osc,
    input wire logic cmp_above,
    input wire logic [1:0] brownout_config,
    input wire logic brownout_fast_start,
    input wire logic wide_supply_part,
    output logic converter_enable,
    output logic conv_busy,
    output logic conv_done_flag,
    output logic [7:0] dac_trial,
    output logic [11:0] ext_chan_sel,
    output logic temp_to_adc,
    output logic ref_to_adc,
    output logic ref_active,
    output logic ref_ready,
    output logic [1:0] ref_gain_sel,
    output logic temp_sense_enable,
    output logic temp_range_sel
);
    acr_pkg::acr_state_t state_q;
    acr_pkg::acr_state_t state_d;
    logic [3:0] input_channel_sel_q;
    logic [2:0] conv_clk_sel_q;
    logic [7:0] conv_result_q;
    logic ref_enable_q;
    logic [5:0] settle_q;
    logic wr;
    logic rd;
    logic hit_chan;
    logic hit_clk;
    logic hit_res;
    logic hit_ref;
    logic hit_stat;
    logic start;
    logic abort;
    logic tad_tick;
    logic sar_complete;
    logic sar_stored;
    logic [7:0] sar_result;
    logic bor_needs_ref;
    logic go_bit;
    logic [7:0] chan_rd;
    logic [7:0] clk_rd;
    logic [7:0] ref_rd;

    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign hit_chan = (paddr == acr_pkg::OFS_CHAN);
    assign hit_clk = (paddr == acr_pkg::OFS_CLK);
    assign hit_res = (paddr == acr_pkg::OFS_RES);
    assign hit_ref = (paddr == acr_pkg::OFS_REF);
    assign hit_stat = (paddr == acr_pkg::OFS_STAT);
    assign pslverr = psel & penable
        & ~(hit_chan | hit_clk | hit_res | hit_ref | hit_stat);

    assign go_bit = (state_q == acr_pkg::ST_CONV);
    // go without enable is ignored; the enable bit must be set in the same write
    assign start = wr & hit_chan & pwdata[acr_pkg::CHAN_GO_BIT]
        & pwdata[acr_pkg::CHAN_EN_BIT] & (state_q == acr_pkg::ST_IDLE);
    // clearing go, or turning the converter off, ends a conversion early
    assign abort = wr & hit_chan & go_bit
        & ~(pwdata[acr_pkg::CHAN_GO_BIT] & pwdata[acr_pkg::CHAN_EN_BIT]);

    acr_tad_gen u_tad (
        .pclk(pclk),
        .presetn(presetn),
        .run(conv_busy),
        .clk_sel(conv_clk_sel_q),
        .rc_osc(rc_osc),
        .tad_tick(tad_tick)
    );

    acr_sar u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(start),
        .abort(abort),
        .tad_tick(tad_tick),
        .cmp_above(cmp_above),
        .busy(conv_busy),
        .complete(sar_complete),
        .stored(sar_stored),
        .result(sar_result),
        .trial(dac_trial)
    );

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            acr_pkg::ST_IDLE:
                if (start)
                    state_d = acr_pkg::ST_CONV; // [RULE16]
            acr_pkg::ST_CONV:
                if (abort || sar_complete)
                    state_d = acr_pkg::ST_DONE; // [RULE16] [RULE20]
            acr_pkg::ST_DONE:
                if (!conv_busy)
                    state_d = acr_pkg::ST_IDLE;
            default:
                state_d = acr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= acr_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_enable <= 1'b0;
            input_channel_sel_q <= acr_pkg::CHAN_SEL_RST;
        end
        else if (wr && hit_chan)
        begin
            converter_enable <= pwdata[acr_pkg::CHAN_EN_BIT];
            input_channel_sel_q <=
                pwdata[acr_pkg::CHAN_SEL_MSB:acr_pkg::CHAN_SEL_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conv_clk_sel_q <= acr_pkg::CLK_SEL_RST;
        else if (wr && hit_clk)
            conv_clk_sel_q <=
                pwdata[acr_pkg::CLK_SEL_MSB:acr_pkg::CLK_SEL_LSB]; // [RULE1]
    end

    // hardware load wins over a software write in the same cycle
    always_ff @(posedge pclk)
    begin
        if (sar_stored)
            conv_result_q <= sar_result; // [RULE17] [RULE19]
        else if (wr && hit_res)
            conv_result_q <= pwdata[7:0]; // [RULE3]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conv_done_flag <= 1'b0;
        else if (sar_complete)
            conv_done_flag <= 1'b1; // [RULE17]
        else if (wr && hit_stat && pwdata[acr_pkg::STAT_DONE_BIT])
            conv_done_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_enable_q <= 1'b0;
            temp_sense_enable <= 1'b0;
            temp_range_sel <= 1'b0;
            ref_gain_sel <= acr_pkg::GAIN_RST;
        end
        else if (wr && hit_ref)
        begin
            ref_enable_q <= pwdata[acr_pkg::REF_EN_BIT]; // [RULE9]
            temp_sense_enable <= pwdata[acr_pkg::TS_EN_BIT]; // [RULE10]
            temp_range_sel <= pwdata[acr_pkg::TS_RNG_BIT]; // [RULE11]
            ref_gain_sel <=
                pwdata[acr_pkg::GAIN_MSB:acr_pkg::GAIN_LSB]; // [RULE12]
        end
    end

    assign bor_needs_ref = (brownout_config == acr_pkg::BOR_ALWAYS)
        | (brownout_fast_start
           & ((brownout_config == acr_pkg::BOR_NO_SLEEP)
              | (brownout_config == acr_pkg::BOR_SOFT)));
    assign ref_active = ref_enable_q | bor_needs_ref; // [RULE9] [RULE15]

    // reference needs a settling period before its output is trusted
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            settle_q <= acr_pkg::CNT_RST;
        else if (!ref_active)
            settle_q <= acr_pkg::CNT_RST;
        else if (settle_q != acr_pkg::REF_SETTLE_CYC)
            settle_q <= settle_q + 6'h01;
    end

    assign ref_ready = wide_supply_part // [RULE8]
        | (ref_active & (settle_q == acr_pkg::REF_SETTLE_CYC)); // [RULE7]

    always_comb
    begin
        ext_chan_sel = '0;
        if (input_channel_sel_q <= acr_pkg::CH_EXT_LAST)
            ext_chan_sel[input_channel_sel_q] = 1'b1; // [RULE18]
    end
    assign temp_to_adc = (input_channel_sel_q == acr_pkg::CH_TEMP); // [RULE18]
    assign ref_to_adc = (input_channel_sel_q == acr_pkg::CH_REF); // [RULE14]

    always_comb
    begin
        chan_rd = 8'h00;
        chan_rd[acr_pkg::CHAN_EN_BIT] = converter_enable;
        chan_rd[acr_pkg::CHAN_GO_BIT] = go_bit;
        chan_rd[acr_pkg::CHAN_SEL_MSB:acr_pkg::CHAN_SEL_LSB] =
            input_channel_sel_q;
        clk_rd = 8'h00; // [RULE2]
        clk_rd[acr_pkg::CLK_SEL_MSB:acr_pkg::CLK_SEL_LSB] = conv_clk_sel_q;
        ref_rd = 8'h00; // [RULE13]
        ref_rd[acr_pkg::REF_RDY_BIT] = ref_ready; // [RULE7]
        ref_rd[acr_pkg::REF_EN_BIT] = ref_enable_q;
        ref_rd[acr_pkg::TS_EN_BIT] = temp_sense_enable;
        ref_rd[acr_pkg::TS_RNG_BIT] = temp_range_sel;
        ref_rd[acr_pkg::GAIN_MSB:acr_pkg::GAIN_LSB] = ref_gain_sel;
    end

    always_comb
    begin
        prdata = '0;
        if (rd)
        begin
            if (hit_chan)
                prdata = acr_pkg::zext(chan_rd);
            else if (hit_clk)
                prdata = acr_pkg::zext(clk_rd);
            else if (hit_res)
                prdata = acr_pkg::zext(conv_result_q);
            else if (hit_ref)
                prdata = acr_pkg::zext(ref_rd);
            else if (hit_stat)
                prdata = acr_pkg::zext({7'h00, conv_done_flag});
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_done_clears_go: assert property (sar_complete |=>
        (!go_bit && conv_done_flag)) // [RULE16]
        else $error("completion did not clear go and set flag");
    a_flag_set_wins: assert property (sar_complete && wr && hit_stat
        |=> conv_done_flag) // [RULE17]
        else $error("done flag lost against clear");
    a_result_loads: assert property (sar_stored |=>
        conv_result_q == $past(sar_result)) // [RULE17]
        else $error("result not loaded on completion");
    a_start_sets_go: assert property (start |=> go_bit ##1 conv_busy)
        // [RULE16]
        else $error("start did not begin conversion");
    a_abort_stores: assert property (abort |=> sar_stored ##1 !go_bit)
        // [RULE19]
        else $error("abort did not store partial result");
    a_clk_reserved: assert property (rd && hit_clk |->
        (prdata[7] == 1'b0 && prdata[3:0] == 4'h0)) // [RULE2]
        else $error("clock control reserved bits not zero");
    a_ref_reserved: assert property (rd && hit_ref |->
        prdata[3:2] == 2'h0) // [RULE13]
        else $error("reference control reserved bits not zero");
    a_wide_ready: assert property (wide_supply_part |-> ref_ready) // [RULE8]
        else $error("wide part ready not one");
    a_ref_settles: assert property ($rose(ref_active) && !wide_supply_part
        |-> !ref_ready [*3]) // [RULE7]
        else $error("reference ready before settling");
    a_bor_ref_on: assert property (brownout_config == acr_pkg::BOR_ALWAYS
        |-> ref_active) // [RULE15]
        else $error("reference off with brown-out always on");
    a_clk_sel_write: assert property (wr && hit_clk |=>
        conv_clk_sel_q == $past(pwdata[6:4])) // [RULE1]
        else $error("clock select not written");
    a_ref_route: assert property (ref_to_adc |-> ext_chan_sel == 12'h000)
        // [RULE14]
        else $error("reference and external channel both routed");

    c_full_conv: cover property (start ##[1:1000] sar_complete);
    c_abort: cover property (start ##[1:200] abort);
    c_rc_conv: cover property (conv_busy && conv_clk_sel_q[1:0]
        == acr_pkg::CLK_RC_CODE && tad_tick);
    c_ref_ready: cover property ($rose(ref_ready) && !wide_supply_part);
endmodule

// File: rtl/acr_pkg.sv
package acr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CHAN = 8'h00;
    localparam logic [7:0] OFS_CLK = 8'h04;
    localparam logic [7:0] OFS_RES = 8'h08;
    localparam logic [7:0] OFS_REF = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // conv_channel_control fields
    localparam int CHAN_EN_BIT = 0;
    localparam int CHAN_GO_BIT = 1;
    localparam int CHAN_SEL_LSB = 2;
    localparam int CHAN_SEL_MSB = 5;
    // conv_clock_control fields
    localparam int CLK_SEL_LSB = 4;
    localparam int CLK_SEL_MSB = 6;
    // voltage_reference_control fields
    localparam int REF_RDY_BIT = 7;
    localparam int REF_EN_BIT = 6;
    localparam int TS_EN_BIT = 5;
    localparam int TS_RNG_BIT = 4;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_MSB = 1;
    // status fields
    localparam int STAT_DONE_BIT = 0;

    // reset values
    localparam logic [3:0] CHAN_SEL_RST = 4'h0;
    localparam logic [2:0] CLK_SEL_RST = 3'h0;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [5:0] CNT_RST = 6'h00;

    // channel codes
    localparam int EXT_CHANNELS = 12;
    localparam logic [3:0] CH_EXT_LAST = 4'hb;
    localparam logic [3:0] CH_TEMP = 4'he;
    localparam logic [3:0] CH_REF = 4'hf;

    localparam logic [1:0] CLK_RC_CODE = 2'h3;
    localparam logic [1:0] GAIN_OFF = 2'h0;

    localparam logic [1:0] BOR_ALWAYS = 2'h3;
    localparam logic [1:0] BOR_NO_SLEEP = 2'h2;
    localparam logic [1:0] BOR_SOFT = 2'h1;

    localparam int CLK_NS = 25;
    localparam int REF_SETTLE_NS = 1000;
    localparam logic [5:0] REF_SETTLE_CYC =
        6'((REF_SETTLE_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_DONE = 2'h3
    } acr_state_t;

    function automatic logic [6:0] tad_divisor(input logic [2:0] sel);
        case (sel)
            3'h0: tad_divisor = 7'h02;
            3'h4: tad_divisor = 7'h04;
            3'h1: tad_divisor = 7'h08;
            3'h5: tad_divisor = 7'h10;
            3'h2: tad_divisor = 7'h20;
            3'h6: tad_divisor = 7'h40;
            default: tad_divisor = 7'h02;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] zext(input logic [7:0] b);
        zext = {{(DATA_W - 8){1'b0}}, b};
    endfunction
endpackage

// File: rtl/acr_tad_gen.sv
`timescale 1ns/10ps
module acr_tad_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] clk_sel,
    input wire logic rc_osc,
    output logic tad_tick
);
    logic [5:0] cnt_q;
    logic [5:0] limit;
    logic rc_meta_q;
    logic rc_sync_q;
    logic rc_prev_q;
    logic rc_mode;

    assign limit = 6'(acr_pkg::tad_divisor(clk_sel) - 7'h01);
    assign rc_mode = (clk_sel[1:0] == acr_pkg::CLK_RC_CODE);

    // rc oscillator is free running and unrelated to pclk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rc_meta_q <= 1'b0;
            rc_sync_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end
        else
        begin
            rc_meta_q <= rc_osc;
            rc_sync_q <= rc_meta_q;
            rc_prev_q <= rc_sync_q;
        end
    end

    always_comb
    begin
        if (!run)
            tad_tick = 1'b0;
        else if (rc_mode)
            tad_tick = rc_sync_q & ~rc_prev_q; // [RULE1] [RULE20]
        else
            tad_tick = (cnt_q == limit); // [RULE1]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= acr_pkg::CNT_RST;
        else if (!run || tad_tick || rc_mode)
            cnt_q <= acr_pkg::CNT_RST;
        else
            cnt_q <= cnt_q + 6'h01;
    end
endmodule

// File: rtl/acr_sar.sv
`timescale 1ns/10ps
module acr_sar (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    input wire logic tad_tick,
    input wire logic cmp_above,
    output logic busy,
    output logic complete,
    output logic stored,
    output logic [7:0] result,
    output logic [7:0] trial
);
    logic [2:0] idx_q;
    logic [7:0] bits_q;
    logic last_q;

    // bits at and below the pending index repeat the last decided bit
    function automatic logic [7:0] fill(input logic [7:0] b,
                                        input logic [2:0] idx,
                                        input logic l);
        logic [7:0] r;
        r = b;
        for (int i = 0; i < 8; i++)
            if (3'(i) <= idx)
                r[i] = l;
        fill = r;
    endfunction

    assign trial = bits_q | (8'h01 << idx_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            complete <= 1'b0;
            stored <= 1'b0;
            idx_q <= 3'h7;
            bits_q <= 8'h00;
            last_q <= 1'b0;
        end
        else
        begin
            complete <= 1'b0;
            stored <= 1'b0;
            if (start && !busy)
            begin
                busy <= 1'b1;
                idx_q <= 3'h7;
                bits_q <= 8'h00;
                last_q <= 1'b0;
            end
            else if (busy && abort)
            begin
                busy <= 1'b0;
                stored <= 1'b1;
            end
            else if (busy && tad_tick)
            begin
                bits_q[idx_q] <= cmp_above;
                last_q <= cmp_above;
                if (idx_q == 3'h0)
                begin
                    busy <= 1'b0;
                    complete <= 1'b1;
                    stored <= 1'b1;
                end
                else
                    idx_q <= idx_q - 3'h1;
            end
        end
    end

    // no reset: result content is undefined until first conversion
    always_ff @(posedge pclk)
    begin
        if (busy && abort)
            result <= fill(bits_q, idx_q, last_q); // [RULE19]
        else if (busy && tad_tick && idx_q == 3'h0)
            result <= {bits_q[7:1], cmp_above};
    end
endmodule

// File: tb/acr_analog_src.sv
`timescale 1ns/10ps
module acr_analog_src (
    input wire logic pclk,
    input wire logic [11:0] ext_chan_sel,
    input wire logic temp_to_adc,
    input wire logic ref_to_adc,
    input wire logic [1:0] ref_gain_sel,
    input wire logic [7:0] dac_trial,
    input wire logic [95:0] ext_level,
    input wire logic [7:0] temp_level,
    output logic cmp_above,
    output logic rc_osc
);
    logic [7:0] lvl;
    logic wobble = 1'b0;
    // rc source runs free, phase unrelated to pclk
    initial
    begin
        rc_osc = 1'b0;
        forever #83 rc_osc = ~rc_osc;
    end
    always @(posedge pclk)
        wobble <= ~wobble;
    always_comb
    begin
        lvl = 8'h00;
        for (int i = 0; i < 12; i++)
            if (ext_chan_sel[i])
                lvl = ext_level[i*8 +: 8];
        if (temp_to_adc)
            lvl = temp_level;
        if (ref_to_adc)
            lvl = (ref_gain_sel == 2'h3) ? 8'hff : {ref_gain_sel, 6'h00};
    end
    // nothing selected: comparator floats, so it keeps changing
    assign cmp_above = (|{ext_chan_sel, temp_to_adc, ref_to_adc}) ?
        (lvl > dac_trial) : wobble;
endmodule

// File: tb/test_adc_clock_result_fvr_control.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("BAD %s exp %h got %h", nm, e, g); \
        end \
    end
module test_adc_clock_result_fvr_control;
    localparam int ACQ = 640;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rc_osc;
    logic [7:0] paddr, dac_trial, temp_level;
    logic [31:0] pwdata, prdata, q;
    logic cmp_above, fast, wide, conv_en, busy, conv_done_flag, e;
    logic [1:0] bor, gain;
    logic [11:0] ext_sel;
    logic [95:0] ext_level;
    logic t2a, r2a, ref_active, ref_ready, ts_en, ts_rng;
    int bad_count = 0;
    int n_compared = 0;
    int divs[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
    int v;

    acr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_osc(rc_osc), .cmp_above(cmp_above),
        .brownout_config(bor), .brownout_fast_start(fast),
        .wide_supply_part(wide), .converter_enable(conv_en),
        .conv_busy(busy), .conv_done_flag(conv_done_flag),
        .dac_trial(dac_trial), .ext_chan_sel(ext_sel),
        .temp_to_adc(t2a), .ref_to_adc(r2a), .ref_active(ref_active),
        .ref_ready(ref_ready), .ref_gain_sel(gain),
        .temp_sense_enable(ts_en), .temp_range_sel(ts_rng));
    acr_analog_src i_src (.pclk(pclk), .ext_chan_sel(ext_sel),
        .temp_to_adc(t2a), .ref_to_adc(r2a), .ref_gain_sel(gain),
        .dac_trial(dac_trial), .ext_level(ext_level),
        .temp_level(temp_level), .cmp_above(cmp_above), .rc_osc(rc_osc));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic conclude();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        // a slave that never answers is a failure, not a silent read
        if (n >= 50)
            bad_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // extra edge so register outputs have landed for the caller
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge pclk);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(nm, x, q)
    endtask

    // reference sar: keep a bit while the input is above the trial
    function automatic logic [7:0] sar(input int lv, input int k);
        int r;
        int last;
        r = 0;
        last = 0;
        for (int i = 7; i >= 8 - k; i--)
        begin
            if (lv > (r | (1 << i)))
                r = r | (1 << i);
            last = (r >> i) & 1;
        end
        for (int i = 7 - k; i >= 0; i--)
            r = r | (last << i);
        return 8'(r);
    endfunction

    task automatic convert(input logic [3:0] ch, input int lv,
        input int div);
        int n;
        repeat (ACQ) @(posedge pclk);
        wr(acr_pkg::OFS_CHAN, acr_pkg::zext({2'h0, ch, 2'h3}));
        n = 0;
        while (conv_done_flag !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        if (div == 0)
            `CHK("rc_time", 1'b1, n < 200)
        else
            `CHK("conv_time", 1'b1, n >= 8*div-1 && n <= 8*div+4)
        `CHK("busy_end", 1'b0, busy)
        rd_chk("go_clear", acr_pkg::OFS_CHAN,
            acr_pkg::zext({2'h0, ch, 2'h1}));
        rd_chk("result", acr_pkg::OFS_RES, sar(lv, 8));
        wr(acr_pkg::OFS_STAT, 32'h1);
        rd_chk("flag_clr", acr_pkg::OFS_STAT, 32'h0);
    endtask

    function automatic int level_of(input int ch);
        if (ch < 12)
            return int'(ext_level[ch*8 +: 8]);
        return (ch == 14) ? int'(temp_level) : 8'h80;
    endfunction

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        bor = 2'h0;
        fast = 1'b0;
        wide = 1'b0;
        ext_level = '0;
        temp_level = 8'h00;
        v = $urandom(32'h93e1a5cc);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("clk_rst", acr_pkg::OFS_CLK, 32'h0);
        rd_chk("ref_rst", acr_pkg::OFS_REF, 32'h0);
        `CHK("pready", 1'b1, pready)
        `CHK("mapped_ok", 1'b0, e)
        wr(acr_pkg::OFS_CLK, 32'hffffffff);
        rd_chk("clk_mask", acr_pkg::OFS_CLK, 32'h70);
        wr(acr_pkg::OFS_RES, 32'hffffffa5);
        rd_chk("res_rw", acr_pkg::OFS_RES, 32'ha5);
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 1'b1, e)
        wr(acr_pkg::OFS_REF, 32'hff);
        rd_chk("ref_wr", acr_pkg::OFS_REF, 32'h73);
        `CHK("ts_en", 1'b1, ts_en)
        `CHK("ts_rng", 1'b1, ts_rng)
        `CHK("ref_act", 1'b1, ref_active)
        repeat (45) @(posedge pclk);
        rd_chk("ref_rdy", acr_pkg::OFS_REF, 32'hf3);
        wr(acr_pkg::OFS_REF, 32'h20);
        `CHK("ts_low", 1'b0, ts_rng)
        rd_chk("ref_off", acr_pkg::OFS_REF, 32'h20);
        for (int g = 0; g < 4; g++)
        begin
            wr(acr_pkg::OFS_REF, 32'(g));
            `CHK("gain", 2'(g), gain)
        end
        for (int c = 0; c < 8; c++)
        begin
            bor <= 2'(c);
            fast <= c[2];
            repeat (2) @(posedge pclk);
            `CHK("bor_ref", c % 4 == 3 || (c % 4 != 0 && c[2]),
                ref_active)
        end
        bor <= 2'h0;
        fast <= 1'b0;
        wr(acr_pkg::OFS_REF, 32'h0);
        wide <= 1'b1;
        rd_chk("ref_wide", acr_pkg::OFS_REF, 32'h80);
        wide <= 1'b0;
        wr(acr_pkg::OFS_REF, 32'h42);
        wr(acr_pkg::OFS_CLK, 32'h0);
        for (int ch = 0; ch < 16; ch++)
        begin
            ext_level <= {$urandom, $urandom, $urandom};
            temp_level <= 8'($urandom);
            wr(acr_pkg::OFS_CHAN, acr_pkg::zext({2'h0, 4'(ch), 2'h1}));
            `CHK("ext_sel", (ch < 12) ? 12'(1 << ch) : 12'h0,
                ext_sel)
            `CHK("temp_sel", ch == 14, t2a)
            `CHK("ref_sel", ch == 15, r2a)
            `CHK("conv_en", 1'b1, conv_en)
            if (ch != 12 && ch != 13)
                convert(4'(ch), level_of(ch), 2);
        end
        for (int c = 0; c < 8; c++)
        begin
            wr(acr_pkg::OFS_CLK, 32'(c << 4));
            rd_chk("clk_sel", acr_pkg::OFS_CLK, 32'(c << 4));
            convert(4'h0, level_of(0), divs[c]);
        end
        // abort mid-way: three bits decided at divide-by-64
        wr(acr_pkg::OFS_CLK, 32'h60);
        wr(acr_pkg::OFS_CHAN, 32'h3);
        repeat (223) @(posedge pclk);
        wr(acr_pkg::OFS_CHAN, 32'h1);
        rd_chk("partial", acr_pkg::OFS_RES, sar(level_of(0), 3));
        `CHK("abort_flag", 1'b0, conv_done_flag)
        `CHK("abort_busy", 1'b0, busy)
        conclude();
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        conclude();
    end
endmodule
